// ==== logic/usdh_cfg.svh ====
`ifndef USDH_CFG_SVH
`define USDH_CFG_SVH

// ==========================================
// register addresses
`define USDH_ADDR_DATA 32'h50001100
`define USDH_ADDR_MASK 32'h50001104
`define USDH_ADDR_FCTL 32'h50001108
`define USDH_ADDR_CTL 32'h5000110C
`define USDH_ADDR_DIV 32'h50001110
`define USDH_ADDR_LSTAT 32'h50001114
`define USDH_ADDR_ISTAT 32'h50001118
`define USDH_SHADOW_RX_TX_DATA_2 32'h50001138
`define USDH_SHADOW_RX_TX_DATA_3 32'h5000113C
`define USDH_SHADOW_FIRST (`USDH_SHADOW_RX_TX_DATA_2 - 32'h00000008)
`define USDH_SHADOW_LAST (`USDH_SHADOW_FIRST + 32'h0000003C)

// ==========================================
// field positions
`define USDH_FC_EN 0
`define USDH_FC_RXCLR 1
`define USDH_FC_TXCLR 2
`define USDH_CTL_IR 0
`define USDH_EV_RX 0
`define USDH_EV_OE 1
`define USDH_EV_TX_HOLDING_EMPTY 2
`define USDH_EV_LOST 3

// ==========================================
// reset values and timing
`define USDH_DIV_RST 16'h0010
`define USDH_DIV_MIN 16'h0002
`define USDH_IR_SHIFT 2
`define USDH_NEV 4

`endif

// ==== logic/usdh_pkg.sv ====
package usdh_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usdh_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usdh_tx_st_t;

endpackage

// ==== logic/usdh_sync.sv ====
`timescale 1ns/1ps

module usdh_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // idle level of both serial inputs is low after reset
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ==== logic/usdh_mem.sv ====
`timescale 1ns/1ps

module usdh_mem #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  // read port, data one edge after the address
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (we)
      mem[wa] <= wd;
  end

  // bypass so a word written this edge is seen at once
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rd_data <= '0;
    else if (we && wa == ra)
      rd_data <= wd;
    else
      rd_data <= mem[ra];
  end

endmodule

// ==== logic/usdh_top.sv ====
`timescale 1ns/1ps
`include "usdh_cfg.svh"

module usdh_top import usdh_pkg::*; #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // serial link
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n,
  // interrupt
  output logic irq
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_C = (AW+1)'(1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("usdh_top: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0] rx_cnt;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW:0] tx_cnt;
    logic [31:0] rdata;
    logic fifo_en;
    logic ir_mode;
    logic [15:0] divisor;
    logic [`USDH_NEV-1:0] mask;
    logic [`USDH_NEV-1:0] istat;
    logic overrun;
    logic irq;
    usdh_rx_st_t rx_st;
    logic [15:0] rx_div;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_z;
    usdh_tx_st_t tx_st;
    logic [15:0] tx_div;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic sout;
    logic sir_out_n;
  } usdh_state_t;

  usdh_state_t s;
  usdh_state_t n;

  // ==========================================
  // input synchronisers and storage
  logic sin_low_s;
  logic sir_s;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic rx_we;
  logic tx_we;
  logic [AW-1:0] rx_wa;
  logic [AW-1:0] tx_wa;

  // plain line inverted ahead of the first stage so both lines idle low, as after reset
  usdh_sync #(.W(2)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .d({sir_in, ~sin}),
    .q({sir_s, sin_low_s})
  );

  // read address looks ahead so the head word is ready on every edge
  usdh_mem #(.W(8), .DEPTH(DEPTH)) u_rx_mem (
    .clock(clock),
    .rstn(rstn),
    .we(rx_we),
    .wa(rx_wa),
    .wd(s.rx_sh),
    .ra(n.rx_rp),
    .rd_data(rx_head)
  );

  usdh_mem #(.W(8), .DEPTH(DEPTH)) u_tx_mem (
    .clock(clock),
    .rstn(rstn),
    .we(tx_we),
    .wa(tx_wa),
    .wd(bus_wdata[7:0]),
    .ra(n.tx_rp),
    .rd_data(tx_head)
  );

  // ==========================================
  // address decode
  logic sh_hit;
  logic rd_data_hit;
  logic wr_data_hit;
  logic ls_read;
  logic is_read;

  assign sh_hit = bus_addr >= `USDH_SHADOW_FIRST && bus_addr <= `USDH_SHADOW_LAST
                  && bus_addr[1:0] == 2'h0;
  assign rd_data_hit = bus_rd && (sh_hit || bus_addr == `USDH_ADDR_DATA);
  assign wr_data_hit = bus_wr && (sh_hit || bus_addr == `USDH_ADDR_DATA);
  assign ls_read = bus_rd && bus_addr == `USDH_ADDR_LSTAT;
  assign is_read = bus_rd && bus_addr == `USDH_ADDR_ISTAT;

  // ==========================================
  // fifo bookkeeping
  logic [AW:0] cap;
  logic rx_push;
  logic rx_pop;
  logic rx_full;
  logic rx_acc;
  logic tx_pop;
  logic tx_full;
  logic tx_acc;
  logic rx_clr;
  logic tx_clr;
  logic fc_wr;
  logic [`USDH_NEV-1:0] ev;

  // fifos off behave as a single-entry holding register
  assign cap = s.fifo_en ? DEPTH_C : ONE_C;
  assign rx_pop = rd_data_hit && s.rx_cnt != '0;
  // a pop in the same cycle frees the slot first
  assign rx_full = (s.rx_cnt - {{AW{1'b0}}, rx_pop}) >= cap;
  assign rx_acc = rx_push && !rx_full;
  assign rx_we = rx_push && (!rx_full || !s.fifo_en);
  assign rx_wa = rx_full ? s.rx_rp : s.rx_wp;
  assign tx_pop = s.tx_st == TX_IDLE && s.tx_cnt != '0;
  assign tx_full = (s.tx_cnt - {{AW{1'b0}}, tx_pop}) >= cap;
  assign tx_acc = wr_data_hit && !tx_full;
  assign tx_we = wr_data_hit && (!tx_full || !s.fifo_en);
  assign tx_wa = tx_full ? s.tx_rp : s.tx_wp;
  // changing the fifo mode flushes both sides
  assign fc_wr = bus_wr && bus_addr == `USDH_ADDR_FCTL;
  assign rx_clr = fc_wr && (bus_wdata[`USDH_FC_EN] != s.fifo_en || bus_wdata[`USDH_FC_RXCLR]);
  assign tx_clr = fc_wr && (bus_wdata[`USDH_FC_EN] != s.fifo_en || bus_wdata[`USDH_FC_TXCLR]);

  assign ev[`USDH_EV_RX] = rx_push;
  assign ev[`USDH_EV_OE] = rx_push && rx_full;
  assign ev[`USDH_EV_TX_HOLDING_EMPTY] = tx_pop && s.tx_cnt == ONE_C && !tx_acc;
  assign ev[`USDH_EV_LOST] = wr_data_hit && tx_full && s.fifo_en;

  // ==========================================
  // serial timing
  logic rx_zero;
  logic rx_mid;
  logic rx_end;
  logic bitz;
  logic tx_end;
  logic tx_lvl;
  logic tx_holding_empty;
  logic temt;

  // infrared zero is a pulse anywhere in the bit, plain zero is sampled mid-bit
  assign rx_zero = s.ir_mode ? sir_s : sin_low_s;
  assign rx_mid = s.rx_div == (s.divisor >> 1);
  // at or past the end, so a divisor lowered mid-frame cannot strand the counter
  assign rx_end = s.rx_div >= s.divisor - 16'h0001;
  assign bitz = s.rx_z | (rx_zero & (s.ir_mode | rx_mid));
  assign rx_push = s.rx_st == RX_STOP && rx_end;
  assign tx_end = s.tx_div >= s.divisor - 16'h0001;
  assign tx_lvl = s.tx_st == TX_START ? 1'b0 : (s.tx_st == TX_DATA ? s.tx_sh[0] : 1'b1);
  assign tx_holding_empty = s.tx_cnt == '0;
  assign temt = tx_holding_empty && s.tx_st == TX_IDLE;

  // ==========================================
  // next state
  always_comb
  begin
    n = s;
    n.rdata = '0;
    if (bus_wr)
    begin
      if (bus_addr == `USDH_ADDR_CTL)
        n.ir_mode = bus_wdata[`USDH_CTL_IR];
      else if (bus_addr == `USDH_ADDR_DIV)
        n.divisor = bus_wdata[15:0] < `USDH_DIV_MIN ? `USDH_DIV_MIN : bus_wdata[15:0];
      else if (bus_addr == `USDH_ADDR_MASK)
        n.mask = bus_wdata[`USDH_NEV-1:0];
      else if (fc_wr)
        n.fifo_en = bus_wdata[`USDH_FC_EN];
    end
    if (rd_data_hit)
      // an empty receive side reads zero, never an unwritten memory word
      n.rdata = {24'h000000, s.rx_cnt != '0 ? rx_head : 8'h00};
    else if (ls_read)
      n.rdata = {25'h0, temt, tx_holding_empty, 3'h0, s.overrun, s.rx_cnt != '0};
    else if (is_read)
      n.rdata = {{(32-`USDH_NEV){1'b0}}, s.istat};
    else if (bus_rd && bus_addr == `USDH_ADDR_MASK)
      n.rdata = {{(32-`USDH_NEV){1'b0}}, s.mask};
    else if (bus_rd && bus_addr == `USDH_ADDR_FCTL)
      n.rdata = {31'h00000000, s.fifo_en};
    else if (bus_rd && bus_addr == `USDH_ADDR_CTL)
      n.rdata = {31'h00000000, s.ir_mode};
    else if (bus_rd && bus_addr == `USDH_ADDR_DIV)
      n.rdata = {16'h0000, s.divisor};

    // receive fifo pointers
    if (rx_pop)
      n.rx_rp = s.rx_rp + 1'b1;
    if (rx_acc)
      n.rx_wp = s.rx_wp + 1'b1;
    n.rx_cnt = s.rx_cnt - {{AW{1'b0}}, rx_pop} + {{AW{1'b0}}, rx_acc};
    if (rx_clr)
    begin
      n.rx_rp = '0;
      n.rx_wp = '0;
      n.rx_cnt = '0;
    end

    // transmit fifo pointers
    if (tx_pop)
      n.tx_rp = s.tx_rp + 1'b1;
    if (tx_acc)
      n.tx_wp = s.tx_wp + 1'b1;
    n.tx_cnt = s.tx_cnt - {{AW{1'b0}}, tx_pop} + {{AW{1'b0}}, tx_acc};
    if (tx_clr)
    begin
      n.tx_rp = '0;
      n.tx_wp = '0;
      n.tx_cnt = '0;
    end

    // sticky flags, a set in the clearing cycle wins
    n.overrun = (ls_read ? 1'b0 : s.overrun) | ev[`USDH_EV_OE];
    n.istat = (is_read ? '0 : s.istat) | ev;
    n.irq = |(n.istat & n.mask);

    // receiver
    unique case (s.rx_st)
      RX_IDLE:
      begin
        if (rx_zero)
        begin
          n.rx_st = RX_START;
          // the detecting edge is the first cycle of the start bit
          n.rx_div = 16'h0001;
          n.rx_z = s.ir_mode;
        end
      end
      RX_START, RX_DATA, RX_STOP:
      begin
        n.rx_div = rx_end ? 16'h0000 : s.rx_div + 16'h0001;
        n.rx_z = rx_end ? 1'b0 : bitz;
        if (rx_end)
        begin
          unique case (s.rx_st)
            RX_START:
            begin
              // a start that is not low at its sample point is noise
              n.rx_st = bitz ? RX_DATA : RX_IDLE;
              n.rx_bit = 3'h0;
            end
            RX_DATA:
            begin
              n.rx_sh = {~bitz, s.rx_sh[7:1]};
              n.rx_bit = s.rx_bit + 3'h1;
              if (s.rx_bit == 3'h7)
                n.rx_st = RX_STOP;
            end
            RX_STOP:
              n.rx_st = RX_IDLE;
            RX_IDLE:
              n.rx_st = RX_IDLE;
          endcase
        end
      end
    endcase

    // transmitter, 8 data bits lsb first and one stop bit
    unique case (s.tx_st)
      TX_IDLE:
      begin
        if (tx_pop)
        begin
          n.tx_sh = tx_head;
          n.tx_st = TX_START;
          n.tx_div = '0;
        end
      end
      TX_START, TX_DATA, TX_STOP:
      begin
        n.tx_div = tx_end ? 16'h0000 : s.tx_div + 16'h0001;
        if (tx_end)
        begin
          unique case (s.tx_st)
            TX_START:
            begin
              n.tx_st = TX_DATA;
              n.tx_bit = 3'h0;
            end
            TX_DATA:
            begin
              n.tx_sh = {1'b0, s.tx_sh[7:1]};
              n.tx_bit = s.tx_bit + 3'h1;
              if (s.tx_bit == 3'h7)
                n.tx_st = TX_STOP;
            end
            TX_STOP:
              n.tx_st = TX_IDLE;
            TX_IDLE:
              n.tx_st = TX_IDLE;
          endcase
        end
      end
    endcase
    // infrared zero is a short low pulse at the start of the bit
    n.sout = s.ir_mode | tx_lvl;
    n.sir_out_n = ~(s.ir_mode & ~tx_lvl & (s.tx_div <= (s.divisor >> `USDH_IR_SHIFT)));
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.divisor <= `USDH_DIV_RST;
      s.sout <= 1'b1;
      s.sir_out_n <= 1'b1;
    end
    else
      s <= n;
  end

  assign bus_rdata = s.rdata;
  assign sout = s.sout;
  assign sir_out_n = s.sir_out_n;
  assign irq = s.irq;

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_read_head: assert property (rd_data_hit
                                |=> bus_rdata == {24'h000000, $past(s.rx_cnt) != '0 ? $past(rx_head) : 8'h00})
    else $error("read data is not the receive head");
  a_alias_pop: assert property (sh_hit && rx_pop && !rx_acc && !rx_clr |=> s.rx_cnt == $past(s.rx_cnt) - ONE_C)
    else $error("shadow read did not pop the receive fifo");
  a_full_drop: assert property (s.fifo_en && rx_push && rx_full && !rx_clr |=> s.overrun && s.rx_cnt == DEPTH_C)
    else $error("full receive fifo did not drop and flag overrun");
  a_over_write: assert property (!s.fifo_en && rx_push && s.rx_cnt == ONE_C && !rx_pop && !rx_clr
                                 |=> s.rx_cnt == ONE_C && s.overrun ##1 rx_head == $past(s.rx_sh, 2))
    else $error("unfifoed overrun did not replace the byte");
  a_tx_holding_empty_clear: assert property (!s.fifo_en && tx_holding_empty && wr_data_hit && !tx_clr |=> !tx_holding_empty)
    else $error("write did not clear holding empty");
  a_tx_overwrite: assert property (!s.fifo_en && s.tx_cnt == ONE_C && wr_data_hit && !tx_pop && !tx_clr
                                   |=> s.tx_cnt == ONE_C ##1 tx_head == $past(bus_wdata[7:0], 2))
    else $error("held character was not overwritten");
  a_tx_depth: assert property (s.tx_cnt <= DEPTH_C && (s.fifo_en || s.tx_cnt <= ONE_C))
    else $error("transmit fifo exceeds its depth");
  a_tx_lost: assert property (s.fifo_en && wr_data_hit && tx_full && !tx_clr
                              |=> s.tx_cnt == DEPTH_C && s.istat[`USDH_EV_LOST])
    else $error("write to full transmit fifo was not dropped");
  a_ir_idle: assert property (s.ir_mode && $past(s.ir_mode) |-> sout)
    else $error("plain output active in infrared mode");
  a_start_bit: assert property (!s.ir_mode && s.tx_st == TX_IDLE && tx_pop ##1 !s.ir_mode |=> !sout [*2])
    else $error("start bit not driven low");

  c_rx_overrun: cover property (s.fifo_en && rx_push && rx_full);
  c_tx_full: cover property (s.tx_cnt == DEPTH_C);
  c_burst_read: cover property (rx_pop && sh_hit ##1 rx_pop && sh_hit);
  c_ir_rx: cover property (s.ir_mode && rx_push);

endmodule

// ==== tb/usdh_link_model.sv ====
`timescale 1ns/1ps

module usdh_link_model #(
  parameter int DIV = 4
) (
  // clock and mode
  input wire logic clock,
  input wire logic ir,
  // device pins
  output logic sin,
  output logic sir_in,
  input wire logic sout,
  input wire logic sir_out_n
);
  initial
  begin
    sin = 1'b1;
    sir_in = 1'b0;
  end

  // ==========
  // far transmitter, 8n1 lsb first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      for (int k = 0; k < DIV; k++)
      begin
        @(posedge clock);
        sin <= ir ? 1'b1 : f[i];
        sir_in <= ir && !f[i] && k < 2;
      end
    end
    // room for the sync stages and the push
    repeat (6) @(posedge clock);
  endtask

  // ==========
  // far receiver; returns a cycle early so a back-to-back start is not missed
  task automatic get(output logic [7:0] b);
    int off;
    off = ir ? 1 : DIV / 2;
    @(posedge clock);
    while ((ir ? sir_out_n : sout) !== 1'b0)
      @(posedge clock);
    repeat (DIV) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (off) @(posedge clock);
      b[i] = ir ? sir_out_n : sout;
      repeat (DIV - off) @(posedge clock);
    end
    repeat (DIV - 1) @(posedge clock);
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "usdh_cfg.svh"

module tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clock, rstn, bus_wr, bus_rd, ir;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, d;
  logic sin, sir_in, sout, sir_out_n, irq;
  logic [7:0] q [0:17];
  int mismatches, checks;

  usdh_top usdh_top_i (
    .clock(clock), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sin(sin),
    .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq)
  );
  usdh_link_model #(.DIV(4)) usdh_link_model_i (
    .clock(clock), .ir(ir), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n)
  );

  // ==========
  // bus and compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    chk({31'h0, sout}, 32'h00000001);
    chk({31'h0, sir_out_n}, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    rc(`USDH_SHADOW_RX_TX_DATA_2, ALL, 32'h00000000);
    rc(`USDH_SHADOW_RX_TX_DATA_3, ALL, 32'h00000000);
    rc(`USDH_ADDR_LSTAT, 32'h00000021, 32'h00000020);
    wr(32'h50001200, 32'h000000AA);
    rc(32'h50001200, ALL, 32'h00000000);
    wr(`USDH_ADDR_DIV, 32'h00000004);
  endtask
  task automatic t_rx_off;
    usdh_link_model_i.send(8'h3C);
    rc(`USDH_ADDR_LSTAT, 32'h00000003, 32'h00000001);
    usdh_link_model_i.send(8'hA5);
    rc(`USDH_ADDR_LSTAT, 32'h00000003, 32'h00000003);
    rc(`USDH_SHADOW_RX_TX_DATA_2, ALL, 32'h000000A5);
    rc(`USDH_ADDR_LSTAT, 32'h00000003, 32'h00000000);
  endtask
  task automatic t_rx_fifo;
    wr(`USDH_ADDR_FCTL, 32'h00000001);
    for (int i = 0; i < 17; i++)
      usdh_link_model_i.send(8'h10 + 8'(i));
    rc(`USDH_ADDR_LSTAT, 32'h00000003, 32'h00000003);
    for (int i = 0; i < 16; i++)
      rc(`USDH_SHADOW_FIRST + 32'(4 * i), ALL, 32'h00000010 + 32'(i));
    rc(`USDH_ADDR_LSTAT, 32'h00000001, 32'h00000000);
  endtask
  task automatic t_tx_off;
    wr(`USDH_ADDR_FCTL, 32'h00000000);
    fork
      begin
        usdh_link_model_i.get(q[0]);
        usdh_link_model_i.get(q[1]);
      end
      begin
        wr(`USDH_SHADOW_RX_TX_DATA_3, 32'h00000081);
        repeat (3) @(posedge clock);
        rc(`USDH_ADDR_LSTAT, 32'h00000020, 32'h00000020);
        wr(`USDH_SHADOW_RX_TX_DATA_3, 32'h00000042);
        rc(`USDH_ADDR_LSTAT, 32'h00000020, 32'h00000000);
        wr(`USDH_SHADOW_RX_TX_DATA_3, 32'h00000024);
      end
    join
    chk({24'h000000, q[0]}, 32'h00000081);
    chk({24'h000000, q[1]}, 32'h00000024);
  endtask
  task automatic t_tx_fifo;
    wr(`USDH_ADDR_FCTL, 32'h00000001);
    fork
      for (int i = 0; i < 17; i++)
        usdh_link_model_i.get(q[i]);
      begin
        // back to back, one edge each, through every alias
        for (int i = 0; i < 18; i++)
        begin
          @(posedge clock);
          bus_wr <= 1'b1;
          bus_addr <= `USDH_SHADOW_FIRST + 32'(4 * (i % 16));
          bus_wdata <= 32'h00000060 + 32'(i);
        end
        @(posedge clock);
        bus_wr <= 1'b0;
      end
    join
    for (int i = 0; i < 17; i++)
      chk({24'h000000, q[i]}, 32'h00000060 + 32'(i));
    rc(`USDH_ADDR_ISTAT, 32'h00000008, 32'h00000008);
    rc(`USDH_ADDR_LSTAT, 32'h00000020, 32'h00000020);
  endtask
  task automatic t_ir;
    @(posedge clock);
    ir <= 1'b1;
    wr(`USDH_ADDR_CTL, 32'h00000001);
    fork
      usdh_link_model_i.get(q[0]);
      begin
        wr(`USDH_SHADOW_RX_TX_DATA_2, 32'h00000096);
        repeat (12) @(posedge clock);
        chk({31'h0, sout}, 32'h00000001);
      end
    join
    chk({24'h000000, q[0]}, 32'h00000096);
    usdh_link_model_i.send(8'hC3);
    rc(`USDH_SHADOW_RX_TX_DATA_3, ALL, 32'h000000C3);
    wr(`USDH_ADDR_CTL, 32'h00000000);
    ir <= 1'b0;
  endtask
  task automatic t_irq;
    wr(`USDH_ADDR_MASK, 32'h00000000);
    rd(`USDH_ADDR_ISTAT, d);
    usdh_link_model_i.send(8'h77);
    chk({31'h0, irq}, 32'h00000000);
    wr(`USDH_ADDR_MASK, 32'h00000001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h00000001);
    rc(`USDH_ADDR_ISTAT, 32'h00000001, 32'h00000001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h00000000);
    rc(`USDH_ADDR_DATA, ALL, 32'h00000077);
  endtask

  // ==========
  // run control
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    rstn = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 32'h00000000;
    bus_wdata = 32'h00000000;
    ir = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_rx_off;
    t_rx_fifo;
    t_tx_off;
    t_tx_fifo;
    t_ir;
    t_irq;
    end_of_test;
  end

  // about two thousand cycles expected
  initial
  begin
    repeat (30000) @(posedge clock);
    mismatches++;
    end_of_test;
  end
endmodule
